// ---- core/xmii_ins_pkg.sv ----
// Constants for the port 5 buffer control, port mux and packet insert registers
// Operation
// - Tx underflow bit15, overflow bit14 sticky
// - Rx underflow bit13, overflow bit12 sticky
// - Bits 5:3 set tx write start delay
// - Bits 2:0 set rx write start delay
// - Bit 9 routes port 6 to insertion
// - Bit 0 routes PHY to external port
// - Inserted bytes go into switch port 6
// - Writing bit 15 triggers byte insertion
// - Trigger is one-cycle self-clearing pulse
// - Bits 7:0 carry the inserted byte
package xmii_ins_pkg;
   localparam logic [15:0] port5_buffer_control_off = 16'h0f12;
   localparam logic [15:0] pin_port_mux_config_off = 16'hf130;
   localparam logic [15:0] packet_insert_off = 16'hf140;
   localparam logic [15:0] irq_status_off = 16'hf150;
   localparam logic [15:0] irq_mask_off = 16'hf151;
   localparam logic [15:0] port5_buffer_control_rst = 16'h0009;
   localparam logic [15:0] pin_port_mux_config_rst = 16'h0000;
   localparam logic [15:0] packet_insert_rst = 16'h0000;
   localparam int tx_ufl_bit = 15;
   localparam int tx_ofl_bit = 14;
   localparam int rx_ufl_bit = 13;
   localparam int rx_ofl_bit = 12;
   localparam int tx_dly_lsb = 3;
   localparam int rx_dly_lsb = 0;
   localparam int dly_w = 3;
   localparam int insert_enable_bit = 9;
   localparam int phy_iso_bit = 0;
   localparam int insert_trigger_bit = 15;
   localparam int insert_valid_bit = 8;
   localparam int irq_w = 5;
   localparam int irq_insert_bit = 4;
endpackage

// ---- core/sticky_flag.sv ----
// Sticky event flag: set wins over clear
`timescale 1ns/1ps
module sticky_flag
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic set,
   input wire logic clr,
   output logic flag
);
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flag <= 1'b0;
      else if (set)
         flag <= 1'b1;
      else if (clr)
         flag <= 1'b0;
   end
endmodule

// ---- core/xmii_buffer_mux_packet_insert.sv ----
// Buffer control, port mux and packet insertion register bank
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module xmii_buffer_mux_packet_insert
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic tx_buf_underflow,
   input wire logic tx_buf_overflow,
   input wire logic rx_buf_underflow,
   input wire logic rx_buf_overflow,
   output logic buf_init,
   output logic [2:0] tx_write_pointer_start_delay,
   output logic [2:0] rx_write_pointer_start_delay,
   output logic insert_extract_enable,
   output logic phy_isolation_select,
   output logic port6_rx_dv,
   output logic [7:0] port6_rxd,
   output logic port6_rx_strobe,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   localparam int irq_w_c = xmii_ins_pkg::irq_w;
   logic [15:0] buf_ctl_q;
   logic [15:0] mux_q;
   logic [8:0] ins_q;
   logic [3:0] ev;
   logic [3:0] flag;
   logic [irq_w_c-1:0] irq_stat;
   logic [irq_w_c-1:0] irq_mask_q;
   logic [irq_w_c-1:0] irq_ev;
   logic trig;
   logic ctl_rd;

   assign ev = {tx_buf_underflow, tx_buf_overflow, rx_buf_underflow, rx_buf_overflow};
   assign ctl_rd = rd && (addr == xmii_ins_pkg::port5_buffer_control_off);
   assign trig = wr && (addr == xmii_ins_pkg::packet_insert_off)
                 && wdata[xmii_ins_pkg::insert_trigger_bit];

   ////////////////////////////////////////////////////////////////////////
   // Sticky buffer flags, cleared by reading the control register
   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_flag
         sticky_flag u_flag
         (
            .clk(clk),
            .resetn(resetn),
            .set(ev[i]),
            .clr(ctl_rd),
            .flag(flag[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         buf_ctl_q <= xmii_ins_pkg::port5_buffer_control_rst;
      else if (wr && addr == xmii_ins_pkg::port5_buffer_control_off)
         buf_ctl_q <= {10'h000, wdata[5:0]};
   end

   // Re-initialise buffers whenever delays are rewritten
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         buf_init <= 1'b1;
      else
         buf_init <= wr && addr == xmii_ins_pkg::port5_buffer_control_off;
   end

   assign tx_write_pointer_start_delay = buf_ctl_q[xmii_ins_pkg::tx_dly_lsb +: xmii_ins_pkg::dly_w];
   assign rx_write_pointer_start_delay = buf_ctl_q[xmii_ins_pkg::rx_dly_lsb +: xmii_ins_pkg::dly_w];

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         mux_q <= xmii_ins_pkg::pin_port_mux_config_rst;
      else if (wr && addr == xmii_ins_pkg::pin_port_mux_config_off)
         mux_q <= wdata & 16'h0201;
   end

   assign insert_extract_enable = mux_q[xmii_ins_pkg::insert_enable_bit];
   assign phy_isolation_select = mux_q[xmii_ins_pkg::phy_iso_bit];

   ////////////////////////////////////////////////////////////////////////
   // Staged byte and valid bit; the trigger bit itself is never stored
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ins_q <= xmii_ins_pkg::packet_insert_rst[8:0];
      else if (wr && addr == xmii_ins_pkg::packet_insert_off)
         ins_q <= wdata[8:0];
   end

   // Byte goes out the cycle after the trigger, with the written data
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         port6_rx_strobe <= 1'b0;
         port6_rx_dv <= 1'b0;
         port6_rxd <= 8'h00;
      end
      else
      begin
         port6_rx_strobe <= trig && insert_extract_enable;
         if (trig && insert_extract_enable)
         begin
            port6_rx_dv <= wdata[xmii_ins_pkg::insert_valid_bit];
            port6_rxd <= wdata[7:0];
         end
         else
            port6_rx_dv <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts: four buffer events plus insertion done
   assign irq_ev = {port6_rx_strobe, ev};
   generate
      for (i = 0; i < irq_w_c; i++)
      begin : g_irq
         sticky_flag u_irq
         (
            .clk(clk),
            .resetn(resetn),
            .set(irq_ev[i]),
            .clr(wr && addr == xmii_ins_pkg::irq_status_off && wdata[i]),
            .flag(irq_stat[i])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_mask_q <= '0;
      else if (wr && addr == xmii_ins_pkg::irq_mask_off)
         irq_mask_q <= wdata[irq_w_c-1:0];
   end

   assign irq = |(irq_stat & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata <= 16'h0000;
      else if (rd)
         case (addr)
            xmii_ins_pkg::port5_buffer_control_off: rdata <= {flag, buf_ctl_q[11:0]};
            xmii_ins_pkg::pin_port_mux_config_off: rdata <= mux_q;
            xmii_ins_pkg::packet_insert_off: rdata <= {7'h00, ins_q};
            xmii_ins_pkg::irq_status_off: rdata <= {11'h000, irq_stat};
            xmii_ins_pkg::irq_mask_off: rdata <= {11'h000, irq_mask_q};
            default: rdata <= 16'h0000;
         endcase
      else
         rdata <= 16'h0000;
   end
endmodule

// ---- tb/xbm_asserts.sv ----
// Checker for the buffer control, mux and insertion bank
`timescale 1ns/1ps
module xbm_chk
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic tx_buf_underflow,
   input wire logic rx_buf_underflow,
   input wire logic [2:0] tx_write_pointer_start_delay,
   input wire logic [2:0] rx_write_pointer_start_delay,
   input wire logic insert_extract_enable,
   input wire logic phy_isolation_select,
   input wire logic port6_rx_dv,
   input wire logic [7:0] port6_rxd,
   input wire logic port6_rx_strobe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_strobe_cause: assert property (port6_rx_strobe |-> $past(wr && addr == 16'hf140 && wdata[15]))
      else $error("strobe without trigger");
   a_trigger_byte: assert property (wr && addr == 16'hf140 && wdata[15] && insert_extract_enable |=>
      port6_rx_strobe && port6_rx_dv == $past(wdata[8]) && port6_rxd == $past(wdata[7:0])) else $error("bad byte");
   a_dv_idle: assert property (!port6_rx_strobe |-> !port6_rx_dv) else $error("dv outside strobe");
   a_enable_write: assert property (wr && addr == 16'hf130 |=> insert_extract_enable == $past(wdata[9]))
      else $error("enable not written");
   a_iso_write: assert property (wr && addr == 16'hf130 |=> phy_isolation_select == $past(wdata[0]))
      else $error("isolation not written");
   a_tx_sticky: assert property (tx_buf_underflow ##1 rd && addr == 16'h0f12 |=> rdata[15])
      else $error("tx flag lost");
   a_rx_read_clear: assert property (rd && addr == 16'h0f12 && !rx_buf_underflow ##1
      rd && addr == 16'h0f12 && !rx_buf_underflow |=> !rdata[13]) else $error("rx flag kept");
   a_delay_write: assert property (wr && addr == 16'h0f12 |=> {tx_write_pointer_start_delay,
      rx_write_pointer_start_delay} == $past(wdata[5:0])) else $error("delays not written");
endmodule
bind xmii_buffer_mux_packet_insert xbm_chk xbm_chk_i (.*);

// ---- tb/port6_sink.sv ----
// Switch port 6 receive side: counts inserted bytes
`timescale 1ns/1ps
module port6_sink
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic strobe,
   input wire logic dv,
   input wire logic [7:0] rxd,
   output logic [15:0] last_q,
   output logic [15:0] n_q
);
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         n_q <= 16'h0000;
         last_q <= 16'h0000;
      end
      else if (strobe)
      begin
         n_q <= n_q + 16'h0001;
         last_q <= {7'h00, dv, rxd};
      end
   end
endmodule

// ---- tb/xmii_buffer_mux_packet_insert_bench.sv ----
// Register-level bench for the buffer control, mux and insertion bank
`timescale 1ns/1ps
module xmii_buffer_mux_packet_insert_bench;
   logic clk = 0, resetn = 0, wr = 0, rd = 0, iee, phy, stb, dv, irq, bi;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, last, n, dl;
   logic [3:0] ev = 4'h0;
   logic [2:0] txd, rxd_dl;
   logic [7:0] rxd;
   int err_count = 0, n_compared = 0, i;
   xmii_buffer_mux_packet_insert xmii_buffer_mux_packet_insert_i (.clk(clk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_buf_underflow(ev[3]), .tx_buf_overflow(ev[2]),
      .rx_buf_underflow(ev[1]), .rx_buf_overflow(ev[0]), .buf_init(bi), .tx_write_pointer_start_delay(txd),
      .rx_write_pointer_start_delay(rxd_dl), .insert_extract_enable(iee), .phy_isolation_select(phy),
      .port6_rx_dv(dv), .port6_rxd(rxd), .port6_rx_strobe(stb), .irq(irq));
   port6_sink port6_sink_i (.clk(clk), .resetn(resetn), .strobe(stb), .dv(dv), .rxd(rxd), .last_q(last), .n_q(n));
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      #1;
   endtask
   task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 check("rdata", e, rdata);
   endtask
   task tally_and_finish;
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      resetn <= 1;
      rd_reg(16'h0f12, 16'h0009);
      rd_reg(16'hf130, 16'h0000);
      rd_reg(16'hf1ee, 16'h0000);
      for (i = 1; i < 7; i++)
      begin
         dl = 16'((i << 3) | (7 - i));
         wr_reg(16'h0f12, 16'hffc0 | dl);
         check("buf init", 16'h0001, {15'h0000, bi});
         rd_reg(16'h0f12, dl);
         check("delay ports", dl, {10'h000, txd, rxd_dl});
      end
      // Event right before two back-to-back reads: flag shown once, then cleared
      @(posedge clk);
      ev <= 4'h8;
      @(posedge clk);
      ev <= 4'h0;
      addr <= 16'h0f12;
      rd <= 1;
      @(posedge clk);
      #1 check("rdata", 16'h8000 | dl, rdata);
      @(posedge clk);
      rd <= 0;
      #1 check("rdata", dl, rdata);
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         ev <= 4'(1 << i);
         @(posedge clk);
         ev <= 4'h0;
         rd_reg(16'h0f12, (16'h1000 << i) | dl);
         rd_reg(16'h0f12, dl);
         check("irq masked", 16'h0000, {15'h0000, irq});
         wr_reg(16'hf151, 16'(1 << i));
         check("irq", 16'h0001, {15'h0000, irq});
         wr_reg(16'hf150, 16'(1 << i));
         check("irq cleared", 16'h0000, {15'h0000, irq});
      end
      wr_reg(16'hf130, 16'hffff);
      rd_reg(16'hf130, 16'h0201);
      check("mux ports", 16'h0003, {14'h0000, iee, phy});
      wr_reg(16'hf151, 16'h0010);
      wr_reg(16'hf140, 16'h81d5);
      wr_reg(16'hf140, 16'h8007);
      rd_reg(16'hf140, 16'h0007);
      check("port6 count", 16'h0002, n);
      check("port6 byte", 16'h0007, last);
      check("irq insert", 16'h0001, {15'h0000, irq});
      rd_reg(16'hf150, 16'h0010);
      // Disabled path must swallow the trigger
      wr_reg(16'hf130, 16'h0000);
      wr_reg(16'hf140, 16'h8155);
      repeat (2) @(posedge clk);
      check("port6 count", 16'h0002, n);
      tally_and_finish;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end
endmodule
